// File: zss_selector.sv
`timescale 1ns/100ps
`default_nettype none
`include "zss_params.svh"
module zss_selector
    import zss_pkg::*;
#(
    parameter int CYC_PER_MS = `ZSS_CYC_PER_MS,
    parameter int WAKE_MS    = `ZSS_WAKE_MS
) (
    input  wire logic               sys_clk_i,
    input  wire logic               rst_i,
    // Register port
    input  wire logic [7:0]         addr_i,
    input  wire logic [31:0]        wdata_i,
    input  wire logic               wr_i,
    input  wire logic               rd_i,
    output logic      [31:0]        rdata_o,
    // Area-switch pins and measured speeds
    input  wire logic [`ZSS_AS_W-1:0] area_switch_i,
    input  wire zss_speed_t         enc1_speed_i,
    input  wire zss_speed_t         enc2_speed_i,
    // Zone set state
    output logic      [6:0]         active_zone_set_o,
    output logic                    zone_fault_o,
    output logic                    switching_o,
    output logic                    sleep_o,
    output logic                    monitoring_o,
    // Encoder scale
    output logic      [9:0]         enc1_ppcm_o,
    output logic      [9:0]         enc2_ppcm_o
);
    localparam int TW = $clog2(CYC_PER_MS);
    localparam int WW = $clog2(WAKE_MS + 1);
    localparam int N  = `ZSS_MAX_SETS;

    // Table of configured zone sets
    logic [`ZSS_AS_W-1:0] code_mem [N];
    zss_speed_t           lo_mem   [N];
    zss_speed_t           hi_mem   [N];

    function automatic logic [3:0] popcnt(input logic [`ZSS_AS_W-1:0] v);
        popcnt = '0;
        for (int k = 0; k < `ZSS_AS_W; k++) popcnt = popcnt + {3'h0, v[k]};
    endfunction

    function automatic logic [15:0] absv(input zss_speed_t v);
        absv = v[15] ? 16'(-v) : 16'(v);
    endfunction

    function automatic logic in_rng(input zss_speed_t v, input zss_speed_t lo,
                                    input zss_speed_t hi);
        in_rng = (v >= lo) && (v <= hi);
    endfunction

    logic [`ZSS_AS_W-1:0] as_level;
    logic                 as_change;

    zss_input_sync #(.W(`ZSS_AS_W)) u_sync (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .pin_i     (area_switch_i),
        .level_o   (as_level),
        .change_o  (as_change)
    );

    zss_state_t           st_reg,    st_next;
    logic [TW-1:0]        div_reg,   div_next;
    logic [12:0]          ms_reg,    ms_next;
    logic [WW-1:0]        wake_reg,  wake_next;
    logic [6:0]           cnt_reg,   cnt_next;
    logic [3:0]           ascnt_reg, ascnt_next;
    logic                 enc_reg,   enc_next;
    logic                 shut_reg,  shut_next;
    logic [7:0]           steps_reg, steps_next;
    logic [5:0]           tol_reg,   tol_next;
    logic [9:0]           pp1_reg,   pp1_next;
    logic [9:0]           pp2_reg,   pp2_next;
    logic [6:0]           idx_reg,   idx_next;
    logic [6:0]           act_reg,   act_next;
    logic [6:0]           lk_reg,    lk_next;
    logic [1:0]           hits_reg,  hits_next;
    logic [6:0]           hit_reg,   hit_next;
    logic [`ZSS_AS_W-1:0] cap_reg,   cap_next;
    logic                 mis_reg,   mis_next;
    logic                 sleep_reg, sleep_next;
    logic                 valid_reg, valid_next;
    logic                 vbusy_reg, vbusy_next;
    logic [6:0]           vi_reg,    vi_next;
    logic [6:0]           vj_reg,    vj_next;
    logic [31:0]          rd_reg,    rd_next;

    logic                 tick;
    logic [`ZSS_AS_W-1:0] mask;
    logic [`ZSS_AS_W-1:0] dif;
    logic                 pair_bad;
    logic                 hit;
    logic [24:0]          mis_lhs;
    logic [24:0]          mis_rhs;
    logic [15:0]          a1;
    logic [15:0]          a2;
    logic                 tbl_wr;

    always_comb begin
        st_next    = st_reg;
        div_next   = div_reg;
        ms_next    = ms_reg;
        wake_next  = wake_reg;
        cnt_next   = cnt_reg;
        ascnt_next = ascnt_reg;
        enc_next   = enc_reg;
        shut_next  = shut_reg;
        steps_next = steps_reg;
        tol_next   = tol_reg;
        pp1_next   = pp1_reg;
        pp2_next   = pp2_reg;
        idx_next   = idx_reg;
        act_next   = act_reg;
        lk_next    = lk_reg;
        hits_next  = hits_reg;
        hit_next   = hit_reg;
        cap_next   = cap_reg;
        mis_next   = mis_reg;
        sleep_next = sleep_reg;
        valid_next = valid_reg;
        vbusy_next = vbusy_reg;
        vi_next    = vi_reg;
        vj_next    = vj_reg;
        rd_next    = '0;
        tbl_wr     = 1'b0;

        // Millisecond enable
        tick = (div_reg == TW'(CYC_PER_MS - 1));
        div_next = tick ? '0 : div_reg + 1'b1;
        if (tick && wake_reg != '0) begin
            wake_next = wake_reg - 1'b1;  // [RL14]
        end

        mask = '0;
        for (int k = 0; k < `ZSS_AS_W; k++) mask[k] = (4'(k) < ascnt_reg);

        // Speed mismatch: ||a|-|b||*100 against tol*max(|a|,|b|)
        a1 = absv(enc1_speed_i);
        a2 = absv(enc2_speed_i);
        mis_lhs = 25'(a1 > a2 ? a1 - a2 : a2 - a1) * 25'd100;
        mis_rhs = 25'(tol_reg) * 25'(a1 > a2 ? a1 : a2);

        // Pair check of the coding walk
        dif = (code_mem[vi_reg] ^ code_mem[vj_reg]) & mask;
        pair_bad = (popcnt(dif) == 4'd1)                               // [RL7]
                || (popcnt(dif) == 4'd0 && (!enc_reg                   // [RL8]
                    || (lo_mem[vi_reg] <= hi_mem[vj_reg]
                        && lo_mem[vj_reg] <= hi_mem[vi_reg])));

        hit = ((code_mem[lk_reg] & mask) == cap_reg)
           && (!enc_reg || in_rng(enc1_speed_i, lo_mem[lk_reg], hi_mem[lk_reg]));  // [RL9]

        // Register writes
        if (wr_i) begin
            unique case (addr_i)
                `ZSS_A_CTRL: begin
                    cnt_next = (wdata_i[6:0] == 7'h00) ? 7'h01
                             : (wdata_i[6:0] > 7'(N)) ? 7'(N) : wdata_i[6:0];  // [RL1]
                    ascnt_next = (wdata_i[`ZSS_CTRL_ASCNT_LSB+:4] == 4'h0) ? 4'h1
                               : (wdata_i[`ZSS_CTRL_ASCNT_LSB+:4] > 4'h8) ? 4'h8
                               : wdata_i[`ZSS_CTRL_ASCNT_LSB+:4];  // [RL10]
                    enc_next   = wdata_i[`ZSS_CTRL_ENC_BIT];
                    shut_next  = wdata_i[`ZSS_CTRL_SHUT_BIT];
                    valid_next = (cnt_next == 7'h01);  // [RL2]
                end
                `ZSS_A_DELAY: steps_next = (wdata_i[7:0] == 8'h00) ? 8'h01 : wdata_i[7:0];  // [RL4]
                `ZSS_A_TOL: tol_next = (wdata_i[5:0] > `ZSS_TOL_MAX) ? `ZSS_TOL_MAX
                                     : wdata_i[5:0];  // [RL11]
                `ZSS_A_PPCM: begin
                    pp1_next = (wdata_i[9:0] < `ZSS_PPCM_MIN) ? `ZSS_PPCM_MIN
                             : (wdata_i[9:0] > `ZSS_PPCM_MAX) ? `ZSS_PPCM_MAX
                             : wdata_i[9:0];  // [RL12]
                    pp2_next = (wdata_i[25:16] < `ZSS_PPCM_MIN) ? `ZSS_PPCM_MIN
                             : (wdata_i[25:16] > `ZSS_PPCM_MAX) ? `ZSS_PPCM_MAX
                             : wdata_i[25:16];  // [RL12]
                end
                `ZSS_A_INDEX: idx_next = (wdata_i[6:0] >= 7'(N)) ? 7'(N - 1) : wdata_i[6:0];
                `ZSS_A_CODE, `ZSS_A_SPEED: begin
                    tbl_wr     = 1'b1;
                    valid_next = (cnt_reg == 7'h01);
                end
                `ZSS_A_CMD: begin
                    if (wdata_i[`ZSS_CMD_VALIDATE] && cnt_reg != 7'h01) begin
                        vbusy_next = 1'b1;
                        valid_next = 1'b1;
                        vi_next    = 7'h00;
                        vj_next    = 7'h01;
                    end
                    if (wdata_i[`ZSS_CMD_CLR_FAULT] && st_reg == ZSS_FAULT) begin
                        st_next = ZSS_IDLE;
                    end
                end
                default: ;
            endcase
        end

        // Coding walk over every pair, one per cycle
        if (vbusy_reg && !tbl_wr && !(wr_i && addr_i == `ZSS_A_CTRL)) begin
            if (pair_bad) valid_next = 1'b0;  // [RL7]
            if (vj_reg == cnt_reg - 7'h01) begin
                if (vi_reg + 7'h02 >= cnt_reg) begin
                    vbusy_next = 1'b0;
                end else begin
                    vi_next = vi_reg + 7'h01;
                    vj_next = vi_reg + 7'h02;
                end
            end else begin
                vj_next = vj_reg + 7'h01;
            end
        end else if (tbl_wr || (wr_i && addr_i == `ZSS_A_CTRL)) begin
            vbusy_next = 1'b0;
        end

        // Switchover ignores safety output state on purpose
        unique case (st_reg)
            ZSS_IDLE: begin
                if (cnt_reg != 7'h01 && as_change) begin  // [RL2] [RL3]
                    st_next = ZSS_DELAY;
                    ms_next = 13'(steps_reg * `ZSS_DELAY_STEP_MS) + 13'h0001;  // [RL4]
                end
            end
            ZSS_DELAY: begin
                // Further edges are bounce; the first one owns the timer
                if (tick) ms_next = ms_reg - 13'h0001;
                if (tick && ms_reg == 13'h0001) begin  // [RL3]
                    st_next   = ZSS_APPLY;
                    cap_next  = as_level & mask;
                    mis_next  = enc_reg && (mis_lhs > mis_rhs);  // [RL11]
                    lk_next   = 7'h00;
                    hits_next = 2'h0;
                end
            end
            ZSS_APPLY: begin
                // At most seventy cycles, far inside the processing bound  [RL5]
                if (hit && hits_reg != 2'h2) begin
                    hits_next = hits_reg + 2'h1;
                    hit_next  = lk_reg;
                end
                lk_next = lk_reg + 7'h01;
                if (as_change) begin
                    st_next = ZSS_FAULT;  // [RL19]
                end else if (lk_reg == cnt_reg - 7'h01) begin
                    if (!valid_reg || mis_reg || hits_next != 2'h1) begin
                        st_next = ZSS_FAULT;  // [RL6] [RL15]
                    end else begin
                        st_next    = ZSS_IDLE;
                        act_next   = hits_next == 2'h1 ? hit_next : act_reg;  // [RL15] [RL16]
                        sleep_next = shut_reg && hit_next == 7'h00;  // [RL13]
                        if (sleep_reg && !sleep_next) begin
                            wake_next = WW'(WAKE_MS);  // [RL14]
                        end
                    end
                end
            end
            ZSS_FAULT: ;
        endcase

        // Read data one cycle later
        if (rd_i) begin
            unique case (addr_i)
                `ZSS_A_CTRL: rd_next = {14'h0, shut_reg, enc_reg, 4'h0, ascnt_reg,
                                        1'b0, cnt_reg};
                `ZSS_A_DELAY:  rd_next = {24'h0, steps_reg};
                `ZSS_A_TOL:    rd_next = {26'h0, tol_reg};
                `ZSS_A_PPCM:   rd_next = {6'h0, pp2_reg, 6'h0, pp1_reg};
                `ZSS_A_STATUS: rd_next = {18'h0, vbusy_reg, valid_reg, wake_reg != '0,
                                          sleep_reg, st_reg != ZSS_IDLE
                                          && st_reg != ZSS_FAULT,
                                          st_reg == ZSS_FAULT, 1'b0, act_reg};
                `ZSS_A_INDEX:  rd_next = {25'h0, idx_reg};
                `ZSS_A_CODE:   rd_next = {24'h0, code_mem[idx_reg]};
                `ZSS_A_SPEED:  rd_next = {hi_mem[idx_reg], lo_mem[idx_reg]};
                default:       rd_next = '0;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (wr_i && addr_i == `ZSS_A_CODE) code_mem[idx_reg] <= wdata_i[`ZSS_AS_W-1:0];
        if (wr_i && addr_i == `ZSS_A_SPEED) begin
            lo_mem[idx_reg] <= wdata_i[15:0];
            hi_mem[idx_reg] <= wdata_i[31:16];
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_reg    <= ZSS_IDLE;
            div_reg   <= '0;
            ms_reg    <= '0;
            wake_reg  <= '0;
            cnt_reg   <= 7'h01;
            ascnt_reg <= 4'h1;
            enc_reg   <= 1'b0;
            shut_reg  <= 1'b0;
            steps_reg <= 8'h01;
            tol_reg   <= `ZSS_TOL_RST;
            pp1_reg   <= `ZSS_PPCM_MIN;
            pp2_reg   <= `ZSS_PPCM_MIN;
            idx_reg   <= '0;
            act_reg   <= '0;
            lk_reg    <= '0;
            hits_reg  <= '0;
            hit_reg   <= '0;
            cap_reg   <= '0;
            mis_reg   <= 1'b0;
            sleep_reg <= 1'b0;
            valid_reg <= 1'b1;
            vbusy_reg <= 1'b0;
            vi_reg    <= '0;
            vj_reg    <= '0;
            rd_reg    <= '0;
        end else begin
            st_reg    <= st_next;
            div_reg   <= div_next;
            ms_reg    <= ms_next;
            wake_reg  <= wake_next;
            cnt_reg   <= cnt_next;
            ascnt_reg <= ascnt_next;
            enc_reg   <= enc_next;
            shut_reg  <= shut_next;
            steps_reg <= steps_next;
            tol_reg   <= tol_next;
            pp1_reg   <= pp1_next;
            pp2_reg   <= pp2_next;
            idx_reg   <= idx_next;
            act_reg   <= act_next;
            lk_reg    <= lk_next;
            hits_reg  <= hits_next;
            hit_reg   <= hit_next;
            cap_reg   <= cap_next;
            mis_reg   <= mis_next;
            sleep_reg <= sleep_next;
            valid_reg <= valid_next;
            vbusy_reg <= vbusy_next;
            vi_reg    <= vi_next;
            vj_reg    <= vj_next;
            rd_reg    <= rd_next;
        end
    end

    assign rdata_o           = rd_reg;
    assign active_zone_set_o = act_reg;
    assign zone_fault_o      = (st_reg == ZSS_FAULT);
    assign switching_o       = (st_reg == ZSS_DELAY) || (st_reg == ZSS_APPLY);
    assign sleep_o           = sleep_reg;  // [RL13]
    assign monitoring_o      = !sleep_reg && (wake_reg == '0) && (st_reg != ZSS_FAULT);
    assign enc1_ppcm_o       = pp1_reg;
    assign enc2_ppcm_o       = pp2_reg;
endmodule // zss_selector
`default_nettype wire

// File: zss_params.svh
// Contract
// RL1 - Up to seventy zone sets held; the inputs pick exactly one at a time.
// RL2 - Default is one zone set; the area-switch inputs are then ignored.
// RL3 - Delay timer starts on the first input transition; no change before expiry.
// RL4 - Input delay is 30 ms minimum and default, raised in 30 ms steps.
// RL5 - The switch completes within 60 ms after the delay expires.
// RL6 - A code matching no configured zone set puts the device in fault.
// RL7 - Coding is valid only if every code pair differs in two bits.
// RL8 - Zone sets sharing a code need non-overlapping speed ranges.
// RL9 - With encoders on, selection uses both input code and measured speed.
// RL10 - With encoders on, the area-switch count is set independently.
// RL11 - Allowed speed mismatch between encoders is 0 to 45 %, default 25 %.
// RL12 - Pulses per centimetre per encoder is 50 to 1000, default 50.
// RL13 - With shut-off on, zone set 1 is a sleep state, motor stopped.
// RL14 - Leaving sleep takes about thirty seconds before monitoring resumes.
// RL15 - After each switchover exactly one zone set is active.
// RL16 - Switchover proceeds even while the safety zone is intruded.
// RL17 - The controller settles all inputs within the input delay.
// RL18 - The controller changes at least two inputs per zone set change.
// RL19 - The controller holds inputs for the 60 ms processing time after the delay.
// RL20 - Each area-switch input is synchronised before transition detection.
`ifndef ZSS_PARAMS_SVH
`define ZSS_PARAMS_SVH

`define ZSS_CLK_HZ          100000000
`define ZSS_MAX_SETS        70
`define ZSS_AS_W            8
`define ZSS_DELAY_STEP_MS   30
`define ZSS_PROC_MAX_MS     60
`define ZSS_WAKE_S          30
`define ZSS_CYC_PER_MS      (`ZSS_CLK_HZ / 1000)
`define ZSS_WAKE_MS         (`ZSS_WAKE_S * 1000)
`define ZSS_TOL_MAX         6'd45
`define ZSS_TOL_RST         6'd25
`define ZSS_PPCM_MIN        10'd50
`define ZSS_PPCM_MAX        10'd1000

`define ZSS_A_CTRL          8'h00
`define ZSS_A_DELAY         8'h04
`define ZSS_A_TOL           8'h08
`define ZSS_A_PPCM          8'h0c
`define ZSS_A_STATUS        8'h10
`define ZSS_A_INDEX         8'h14
`define ZSS_A_CODE          8'h18
`define ZSS_A_SPEED         8'h1c
`define ZSS_A_CMD           8'h20

`define ZSS_CTRL_ASCNT_LSB  8
`define ZSS_CTRL_ENC_BIT    16
`define ZSS_CTRL_SHUT_BIT   17
`define ZSS_CMD_VALIDATE    0
`define ZSS_CMD_CLR_FAULT   1

`endif

// File: zss_pkg.sv
package zss_pkg;
    typedef enum logic [1:0] {
        ZSS_IDLE  = 2'b00,
        ZSS_DELAY = 2'b01,
        ZSS_APPLY = 2'b11,
        ZSS_FAULT = 2'b10
    } zss_state_t;
    typedef logic signed [15:0] zss_speed_t;
endpackage

// File: zss_input_sync.sv
`timescale 1ns/100ps
`default_nettype none
module zss_input_sync #(
    parameter int W = 8
) (
    input  wire logic         sys_clk_i,
    input  wire logic         rst_i,
    // Pins
    input  wire logic [W-1:0] pin_i,
    // Synchronised view
    output logic      [W-1:0] level_o,
    output logic              change_o
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] sync_reg;
    logic [W-1:0] prev_reg;

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_reg <= '0;
            sync_reg <= '0;
            prev_reg <= '0;
        end else begin
            meta_reg <= pin_i;     // [RL20]
            sync_reg <= meta_reg;  // [RL20]
            prev_reg <= sync_reg;
        end
    end

    assign level_o  = sync_reg;
    assign change_o = (sync_reg != prev_reg);  // [RL3]
endmodule // zss_input_sync
`default_nettype wire

// File: zss_selector_sva.sv
`timescale 1ns/100ps
`default_nettype none
`include "zss_params.svh"
module zss_selector_sva #(
    parameter int CYC_PER_MS = `ZSS_CYC_PER_MS,
    parameter int WAKE_MS    = `ZSS_WAKE_MS
) (
    // Clock and reset
    input wire logic        sys_clk_i,
    input wire logic        rst_i,
    // Register writes
    input wire logic [7:0]  addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic        wr_i,
    // Zone set state and encoder scale
    input wire logic [6:0]  active_zone_set_o,
    input wire logic        zone_fault_o,
    input wire logic        switching_o,
    input wire logic        sleep_o,
    input wire logic        monitoring_o,
    input wire logic [9:0]  enc1_ppcm_o,
    input wire logic [9:0]  enc2_ppcm_o
);
    // Tick alignment and lookup must fit inside the processing budget
    localparam int PROC_CYC = `ZSS_PROC_MAX_MS * CYC_PER_MS;
    logic [7:0] steps_reg, steps_next;
    logic       one_reg, one_next;
    int         cnt_reg, cnt_next;
    int         dly_cyc;

    function automatic logic [9:0] ppcm_lim(input logic [9:0] v);
        return (v < 10'h032) ? 10'h032 : (v > 10'h3e8) ? 10'h3e8 : v;
    endfunction

    always_comb begin
        steps_next = steps_reg;
        one_next   = one_reg;
        cnt_next   = switching_o ? cnt_reg + 1 : 0;
        if (wr_i && addr_i == `ZSS_A_DELAY) begin
            steps_next = (wdata_i[7:0] == 8'h00) ? 8'h01 : wdata_i[7:0];
        end
        if (wr_i && addr_i == `ZSS_A_CTRL) begin
            one_next = wdata_i[6:0] <= 7'h01;
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            steps_reg <= 8'h01;
            one_reg   <= 1'b1;
            cnt_reg   <= 0;
        end else begin
            steps_reg <= steps_next;
            one_reg   <= one_next;
            cnt_reg   <= cnt_next;
        end
    end

    assign dly_cyc = int'(steps_reg) * `ZSS_DELAY_STEP_MS * CYC_PER_MS;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    a_no_early_switch: assert property ($fell(switching_o) |-> cnt_reg >= dly_cyc)
        else $error("switch ended before the input delay");
    a_switch_bounded: assert property (switching_o |-> cnt_reg <= dly_cyc + PROC_CYC)
        else $error("switch took longer than delay plus processing");
    a_active_hold: assert property ($changed(active_zone_set_o) |-> !switching_o
        && ($past(switching_o) || $past(switching_o, 2)))
        else $error("active zone set moved outside a switch");
    a_active_range: assert property (active_zone_set_o <= 7'h45)
        else $error("active zone set out of range");
    a_one_set: assert property (one_reg |-> !$rose(switching_o))
        else $error("switch started with a single zone set");
    a_fault_stop: assert property (zone_fault_o |-> !monitoring_o && !switching_o)
        else $error("fault with monitoring or switching");
    a_sleep_zone: assert property (sleep_o |-> active_zone_set_o == 7'h00 && !monitoring_o)
        else $error("sleep outside zone set 1");
    a_wake_delay: assert property ($fell(sleep_o) |-> !monitoring_o [*8])
        else $error("monitoring resumed at once after sleep");
    a_ppcm_range: assert property (ppcm_lim(enc1_ppcm_o) == enc1_ppcm_o
        && ppcm_lim(enc2_ppcm_o) == enc2_ppcm_o)
        else $error("encoder scale out of range");
    a_ppcm_write: assert property (wr_i && addr_i == `ZSS_A_PPCM |=>
        enc1_ppcm_o == ppcm_lim($past(wdata_i[9:0]))
        && enc2_ppcm_o == ppcm_lim($past(wdata_i[25:16])))
        else $error("encoder scale write not applied");

    c_switch_ok: cover property ($fell(switching_o) && !zone_fault_o);
    c_fault: cover property ($rose(zone_fault_o));
    c_wake: cover property ($fell(sleep_o));
endmodule // zss_selector_sva

bind zss_selector zss_selector_sva #(.CYC_PER_MS(CYC_PER_MS), .WAKE_MS(WAKE_MS))
    zss_selector_sva_i (.sys_clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .active_zone_set_o,
    .zone_fault_o, .switching_o, .sleep_o, .monitoring_o, .enc1_ppcm_o, .enc2_ppcm_o);
`default_nettype wire

// File: zss_plc_model.sv
`timescale 1ns/100ps
`default_nettype none
module zss_plc_model (
    // Clock and reset
    input  wire logic       sys_clk_i,
    input  wire logic       rst_i,
    // Command from the bench
    input  wire logic       go_i,
    input  wire logic [7:0] code_i,
    // Area-switch pins
    output logic      [7:0] pins_o
);
    logic [7:0] tgt_reg, tgt_next, pins_next, diff;
    logic [2:0] gap_reg, gap_next;

    always_comb begin
        tgt_next  = go_i ? code_i : tgt_reg;
        diff      = tgt_reg ^ pins_o;
        pins_next = pins_o;
        gap_next  = gap_reg + 3'h1;
        // Skewed edges, one pin per 8 cycles, all well inside the delay
        if (diff != 8'h00 && gap_reg == 3'h7) begin
            pins_next = pins_o ^ (diff & (~diff + 8'h01));
        end
    end

    // Pins held until the next command
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            tgt_reg <= 8'h00;
            pins_o  <= 8'h00;
            gap_reg <= 3'h0;
        end else begin
            tgt_reg <= tgt_next;
            pins_o  <= pins_next;
            gap_reg <= gap_next;
        end
    end
endmodule // zss_plc_model
`default_nettype wire

// File: tb_zss_selector.sv
`timescale 1ns/100ps
`default_nettype none
`include "zss_params.svh"
module tb_zss_selector
    import zss_pkg::*;
;
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_count++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
    localparam int CPM = 10;
    // Pairwise two bits apart
    localparam logic [7:0] CODES [4] = '{8'h00, 8'h03, 8'h05, 8'h06};
    logic        sys_clk_i = 1'b0;
    logic        rst_i     = 1'b1;
    logic [7:0]  addr_i    = 8'h00;
    logic [31:0] wdata_i   = 32'h0;
    logic        wr_i      = 1'b0;
    logic        rd_i      = 1'b0;
    logic        go        = 1'b0;
    logic [7:0]  code      = 8'h00;
    zss_speed_t  spd       = 16'h0000;
    logic [31:0] lfsr      = 32'hc321ba7b;
    logic [31:0] rdata_o;
    logic [7:0]  pins;
    logic [6:0]  active;
    logic        fault, sw, slp, mon;
    logic [9:0]  p1, p2;
    int          err_count = 0;
    int          n_tests   = 0;
    int          cyc       = 0;
    int          idx;

    zss_selector #(.CYC_PER_MS(CPM), .WAKE_MS(5)) zss_selector_i (
        .sys_clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
        .area_switch_i(pins), .enc1_speed_i(spd), .enc2_speed_i(spd),
        .active_zone_set_o(active), .zone_fault_o(fault), .switching_o(sw),
        .sleep_o(slp), .monitoring_o(mon), .enc1_ppcm_o(p1), .enc2_ppcm_o(p2));
    zss_plc_model zss_plc_model_i (.sys_clk_i, .rst_i, .go_i(go), .code_i(code), .pins_o(pins));

    initial begin
        forever #5 sys_clk_i = ~sys_clk_i;
    end

    function automatic logic [31:0] step(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    task automatic conclude();
        $display("tests=%0d errors=%0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    always @(posedge sys_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            err_count++;
            conclude();
        end
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge sys_clk_i);
        wr_i <= 1'b0;
    endtask

    task automatic chk_rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        @(posedge sys_clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge sys_clk_i);
        rd_i <= 1'b0;
        #1;
        `CHK(rdata_o & m, e)
    endtask

    // Command the controller, then follow the switch to its end
    task automatic sel(input int i, input logic [7:0] c, input logic f);
        int n;
        lfsr = step(lfsr);
        @(posedge sys_clk_i);
        go   <= 1'b1;
        code <= c;
        spd  <= {1'b0, lfsr[14:0]};
        @(posedge sys_clk_i);
        go <= 1'b0;
        for (n = 0; n < 150 && !sw; n++) @(negedge sys_clk_i);
        `CHK(sw, 1'b1)
        for (n = 0; n < 2000 && sw; n++) @(negedge sys_clk_i);
        `CHK(fault, f)
        if (!f) `CHK(active, i[6:0])
        $display("switch to %0d code %h done", i, c);
    endtask

    initial begin
        repeat (10) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        chk_rd(`ZSS_A_STATUS, 32'h3fff, 32'h1000);
        chk_rd(`ZSS_A_PPCM, 32'h03ff03ff, 32'h00320032);
        chk_rd(`ZSS_A_TOL, 32'h3f, 32'h19);
        chk_rd(`ZSS_A_DELAY, 32'hff, 32'h1);
        wr(`ZSS_A_PPCM, 32'h03ff000a);
        #1;
        `CHK({p1, p2}, {10'h032, 10'h3e8})
        wr(`ZSS_A_TOL, 32'h3c);
        chk_rd(`ZSS_A_TOL, 32'h3f, 32'h2d);
        @(posedge sys_clk_i);
        go <= 1'b1;
        code <= 8'h03;
        @(posedge sys_clk_i);
        go <= 1'b0;
        repeat (400) @(posedge sys_clk_i);
        `CHK({sw, active}, 8'h00)
        $display("single zone set done");
        wr(`ZSS_A_CTRL, 32'h64);
        chk_rd(`ZSS_A_CTRL, 32'h7f, 32'h46);
        wr(`ZSS_A_CTRL, 32'h00020404);
        for (int i = 0; i < 4; i++) begin
            wr(`ZSS_A_INDEX, i);
            wr(`ZSS_A_CODE, {24'h0, CODES[i]});
        end
        for (int k = 0; k < 3; k++) begin
            if (k == 1) wr(`ZSS_A_CODE, 32'h01);
            if (k == 2) wr(`ZSS_A_CODE, 32'h06);
            wr(`ZSS_A_CMD, 32'h1);
            repeat (30) @(posedge sys_clk_i);
            chk_rd(`ZSS_A_STATUS, 32'h1000, (k == 1) ? 32'h0 : 32'h1000);
        end
        for (int k = 0; k < 8; k++) begin
            lfsr = step(lfsr);
            wr(`ZSS_A_DELAY, 32'h1 + lfsr[4]);
            idx = 1 + lfsr[7:0] % 3;
            if (CODES[idx] == pins) idx = (idx % 3) + 1;
            sel(idx, CODES[idx], 1'b0);
        end
        sel(0, CODES[0], 1'b0);
        `CHK({slp, mon}, 2'b10)
        sel(1, CODES[1], 1'b0);
        `CHK({slp, mon}, 2'b00)
        repeat (5 * CPM + 20) @(posedge sys_clk_i);
        `CHK(mon, 1'b1)
        sel(0, 8'h07, 1'b1);
        `CHK(mon, 1'b0)
        wr(`ZSS_A_CMD, 32'h2);
        @(negedge sys_clk_i);
        `CHK(fault, 1'b0)
        sel(2, CODES[2], 1'b0);
        // Encoder on; set 4 takes only negative speeds, bench speeds are positive
        wr(`ZSS_A_CTRL, 32'h00010404);
        for (int i = 0; i < 4; i++) begin
            wr(`ZSS_A_INDEX, i);
            wr(`ZSS_A_SPEED, (i == 3) ? 32'hffff8000 : 32'h7fff8000);
        end
        wr(`ZSS_A_CMD, 32'h1);
        repeat (30) @(posedge sys_clk_i);
        sel(3, CODES[3], 1'b1);
        conclude();
    end
endmodule // tb_zss_selector
`default_nettype wire
